// ===== shared/ssfe_pkg.sv
/*
 * Constants for the static field encoder: register map, field layout,
 * size bounds and offset steps, all in decimetres.
 * Assumes nothing of its surroundings; included by package name only.
 */
`default_nettype none
package ssfe_pkg;
   // ****************************************************************
   // Register map and fields
   // ****************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DIMS = 8'h04;
   localparam logic [7:0] OFS_ANT = 8'h08;
   localparam logic [7:0] OFS_CFG = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_HEIGHT = 8'h14;
   localparam int CTRL_GO = 0;
   localparam int CTRL_CLR = 1;
   localparam int CFG_SIZE_KNOWN = 0;
   localparam int CFG_LAT_KNOWN = 1;
   localparam int CFG_LON_KNOWN = 2;
   localparam int CFG_LON_APPLIED = 3;
   localparam int ANT_LAT_LSB = 0;
   localparam int ANT_LAT_RIGHT = 10;
   localparam int ANT_LON_LSB = 16;
   localparam int WID_LSB = 16;
   localparam logic [3:0] CFG_RESET = 4'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HRESP_OKAY = 2'h0;
   // ****************************************************************
   // Widths and encoding constants
   // ****************************************************************
   localparam int DIM_W = 16;
   localparam int OFS_W = 10;
   localparam int ALT_W = 24;
   localparam logic [3:0] SZ_NODATA = 4'h0;
   localparam logic [3:0] SZ_CODE_MAX = 4'hf;
   localparam logic [DIM_W-1:0] SZ_LEN_MAX_DM = 16'h0352;
   localparam logic [DIM_W-1:0] SZ_WID_MAX_DM = 16'h0384;
   // Upper bounds for codes 15 down to 1, element index is code minus one.
   localparam logic [14:0][15:0] SZ_LEN_DM = {16'h0352, 16'h0352, 16'h02ee, 16'h02ee, 16'h028a,
      16'h028a, 16'h0226, 16'h0226, 16'h01c2, 16'h01c2, 16'h015e, 16'h015e, 16'h00fa, 16'h00fa, 16'h0096};
   localparam logic [14:0][15:0] SZ_WID_DM = {16'h0384, 16'h0320, 16'h0320, 16'h02d5, 16'h029e,
      16'h0253, 16'h0208, 16'h01c2, 16'h01c2, 16'h018b, 16'h017c, 16'h014a, 16'h0154, 16'h011d, 16'h00e6};
   localparam logic [OFS_W-1:0] STEP_DM = 10'h014;
   localparam logic [OFS_W-1:0] HALF_STEP_DM = 10'h00a;
   localparam logic [OFS_W-1:0] LAT_CAP_DM = 10'h032;
   localparam logic [OFS_W-1:0] LON_CAP_DM = 10'h258;
   localparam logic [2:0] LAT_NODATA = 3'h0;
   localparam logic [2:0] LAT_ZERO = 3'h4;
   localparam logic [4:0] LON_NODATA = 5'h00;
   localparam logic [4:0] LON_APPLIED = 5'h01;
   localparam logic [4:0] LON_MIN = 5'h02;
   localparam logic [4:0] LON_MAX = 5'h1f;
   localparam logic [15:0] VACC_45_M = 16'h002d;
   localparam logic [15:0] VACC_150_M = 16'h0096;
   localparam logic [1:0] VACC_UNKNOWN = 2'h0;
   localparam logic [1:0] VACC_150 = 2'h1;
   localparam logic [1:0] VACC_45 = 2'h2;

   function automatic logic [15:0] sz_len_bound(input logic [3:0] code);
      sz_len_bound = SZ_LEN_DM[code-4'h1];
   endfunction

   function automatic logic [15:0] sz_wid_bound(input logic [3:0] code);
      sz_wid_bound = SZ_WID_DM[code-4'h1];
   endfunction
endpackage
`default_nettype wire

// ===== shared/ssfe_enc_if.sv
/*
 * Carrier between the register block and the two field encoders.
 * Assumes the encoders are purely combinational.
 */
`timescale 1ns/100ps
`default_nettype none
interface ssfe_enc_if;
   logic [15:0] len_dm;
   logic [15:0] wid_dm;
   logic size_known;
   logic [3:0] size_code;
   logic [9:0] lat_dm;
   logic lat_right;
   logic lat_known;
   logic [2:0] lat_code;
   logic [9:0] lon_dm;
   logic lon_known;
   logic lon_applied;
   logic [4:0] lon_code;
   modport top_mp (output len_dm, wid_dm, size_known, lat_dm, lat_right, lat_known, lon_dm, lon_known,
      lon_applied, input size_code, lat_code, lon_code);
   modport size_mp (input len_dm, wid_dm, size_known, output size_code);
   modport offs_mp (input lat_dm, lat_right, lat_known, lon_dm, lon_known, lon_applied, output lat_code, lon_code);
endinterface
`default_nettype wire

// ===== design/ssfe_size_enc.sv
/*
 * Combined length and width size code, combinational.
 * Assumes dimensions in decimetres from the register block.
 */
`timescale 1ns/100ps
`default_nettype none
module ssfe_size_enc (
   ssfe_enc_if.size_mp enc
);
   always_comb begin
      enc.size_code = ssfe_pkg::SZ_NODATA;
      if (enc.size_known) begin
         enc.size_code = ssfe_pkg::SZ_CODE_MAX;
         for (int i = 15; i >= 1; i--) begin
            if (enc.len_dm <= ssfe_pkg::sz_len_bound(4'(i)) && enc.wid_dm <= ssfe_pkg::sz_wid_bound(4'(i))) begin
               enc.size_code = 4'(i);
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== design/ssfe_offs_enc.sv
/*
 * Lateral and longitudinal antenna offset codes, combinational.
 * Assumes offset magnitudes in decimetres from the register block.
 */
`timescale 1ns/100ps
`default_nettype none
module ssfe_offs_enc (
   ssfe_enc_if.offs_mp enc
);
   logic [1:0] lat_steps;
   logic [10:0] lon_q;
   logic [4:0] lon_c;

   always_comb begin
      if (enc.lat_dm >= ssfe_pkg::LAT_CAP_DM) begin
         lat_steps = 2'h3;
      end else if (enc.lat_dm >= ssfe_pkg::HALF_STEP_DM + ssfe_pkg::STEP_DM) begin
         lat_steps = 2'h2;
      end else if (enc.lat_dm >= ssfe_pkg::HALF_STEP_DM) begin
         lat_steps = 2'h1;
      end else begin
         lat_steps = 2'h0;
      end
      if (!enc.lat_known) begin
         enc.lat_code = ssfe_pkg::LAT_NODATA;
      end else if (lat_steps == 2'h0) begin
         enc.lat_code = ssfe_pkg::LAT_ZERO;
      end else begin
         enc.lat_code = {enc.lat_right, lat_steps};
      end
   end

   always_comb begin
      lon_q = ({1'b0, enc.lon_dm} + {1'b0, ssfe_pkg::HALF_STEP_DM}) / {1'b0, ssfe_pkg::STEP_DM};
      lon_c = lon_q[4:0] + 5'h1;
      if (!enc.lon_known) begin
         enc.lon_code = ssfe_pkg::LON_NODATA;
      end else if (enc.lon_applied) begin
         enc.lon_code = ssfe_pkg::LON_APPLIED;
      end else if (enc.lon_dm > ssfe_pkg::LON_CAP_DM) begin
         enc.lon_code = ssfe_pkg::LON_MAX;
      end else if (lon_c < ssfe_pkg::LON_MIN) begin
         enc.lon_code = ssfe_pkg::LON_MIN;
      end else begin
         enc.lon_code = lon_c;
      end
   end
endmodule
`default_nettype wire

// ===== design/ssfe_top.sv
/*
 * Static field encoder top: AHB-Lite register slave, position source
 * capture and registered field outputs for the message assembly logic.
 * Assumes one clock, position source inputs on that clock, ce high
 * whenever the bus is active.
 */
// How it works
// - Pick the lowest size code whose length and width bounds both fit.
// - Longer than 85 m or wider than 90 m gives code 15.
// - Size code is four bits: three length bits, one width bit last.
// - Length and width upper bounds per code follow the fixed table.
// - Lateral top bit gives direction, zero left and one right.
// - Lateral magnitude in two low bits, two metre steps up to six.
// - Lateral offsets above six metres saturate at the six metre code.
// - Lateral 000 means no data, 100 means an offset under one metre.
// - Offsets round to the nearest two metre step, plus or minus one.
// - Longitudinal five bits: 00000 no data, 00001 applied by source.
// - Longitudinal codes two to 31 are distance over two plus one.
// - Longitudinal offsets above sixty metres saturate at all ones.
// - Vertical accuracy code: 0 unknown, 1 within 150, 2 within 45.
// - Ellipsoid height goes to both position and velocity messages.
`timescale 1ns/100ps
`default_nettype none
module ssfe_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic [1:0] hresp,
   input wire logic pos_valid,
   input wire logic [23:0] pos_height,
   input wire logic pos_vacc_known,
   input wire logic [15:0] pos_vacc_m,
   output logic out_valid,
   output logic [3:0] size_code,
   output logic [2:0] lat_code,
   output logic [4:0] lon_code,
   output logic [1:0] vertical_accuracy_code,
   output logic [23:0] posmsg_ellipsoid_height,
   output logic [23:0] velmsg_ellipsoid_height
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_DATA = 2'b10
   } ssfe_bus_st_t;

   ssfe_bus_st_t bus_st_q;
   logic ap_take;
   logic dp_wr_q;
   logic [7:0] dp_addr_q;
   logic wr_now;
   logic rd_now;
   logic hreadyout_q;
   logic [31:0] hrdata_q;
   logic [1:0] hresp_q;
   logic [31:0] rd_word;
   logic [15:0] len_q;
   logic [15:0] wid_q;
   logic [9:0] lat_dm_q;
   logic lat_right_q;
   logic [9:0] lon_dm_q;
   logic [3:0] cfg_q;
   logic go_q;
   logic clr_now;
   logic fire;
   logic out_valid_q;
   logic [3:0] size_code_q;
   logic [2:0] lat_code_q;
   logic [4:0] lon_code_q;
   logic [1:0] vacc_code_q;
   logic [1:0] vacc_code_d;
   logic [23:0] pos_height_q;
   logic [23:0] vel_height_q;

   ssfe_enc_if enc ();

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   // Only whole-word single transfers are expected, so hsize is not decoded.
   assign ap_take = hsel && hready && htrans == ssfe_pkg::HTRANS_NONSEQ && ce;
   assign wr_now = ce && bus_st_q == BUS_DATA && dp_wr_q;
   assign rd_now = ce && bus_st_q == BUS_DATA && !dp_wr_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_st_q <= BUS_IDLE;
         dp_wr_q <= 1'b0;
         dp_addr_q <= 8'h00;
         hreadyout_q <= 1'b1;
      end else if (ce) begin
         unique case (bus_st_q)
            BUS_IDLE: begin
               if (ap_take) begin
                  bus_st_q <= BUS_DATA;
                  dp_wr_q <= hwrite;
                  dp_addr_q <= haddr[7:0];
                  hreadyout_q <= 1'b0;
               end
            end
            BUS_DATA: begin
               bus_st_q <= BUS_IDLE;
               hreadyout_q <= 1'b1;
            end
         endcase
      end
   end

   // Unmapped offsets read as zero, haddr above bit 7 is ignored; bits above each field read as zero too.
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (dp_addr_q)
         ssfe_pkg::OFS_DIMS: rd_word = {wid_q, len_q};
         ssfe_pkg::OFS_ANT: rd_word = {6'h00, lon_dm_q, 5'h00, lat_right_q, lat_dm_q};
         ssfe_pkg::OFS_CFG: rd_word = {28'h000_0000, cfg_q};
         ssfe_pkg::OFS_STATUS: rd_word = {18'h0_0000, vacc_code_q, lon_code_q, lat_code_q, size_code_q};
         ssfe_pkg::OFS_HEIGHT: rd_word = {8'h00, pos_height_q};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
         hresp_q <= ssfe_pkg::HRESP_OKAY;
      end else if (ce) begin
         hresp_q <= ssfe_pkg::HRESP_OKAY;
         if (rd_now) begin
            hrdata_q <= rd_word;
         end
      end
   end

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         len_q <= 16'h0000;
         wid_q <= 16'h0000;
      end else if (wr_now && dp_addr_q == ssfe_pkg::OFS_DIMS) begin
         len_q <= hwdata[15:0];
         wid_q <= hwdata[ssfe_pkg::WID_LSB +: 16];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lat_dm_q <= 10'h000;
         lat_right_q <= 1'b0;
         lon_dm_q <= 10'h000;
      end else if (wr_now && dp_addr_q == ssfe_pkg::OFS_ANT) begin
         lat_dm_q <= hwdata[ssfe_pkg::ANT_LAT_LSB +: 10];
         lat_right_q <= hwdata[ssfe_pkg::ANT_LAT_RIGHT];
         lon_dm_q <= hwdata[ssfe_pkg::ANT_LON_LSB +: 10];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q <= ssfe_pkg::CFG_RESET;
      end else if (wr_now && dp_addr_q == ssfe_pkg::OFS_CFG) begin
         cfg_q <= hwdata[3:0];
      end
   end

   // The go bit is a self-clearing pulse; it reads back as zero.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         go_q <= 1'b0;
      end else if (ce) begin
         go_q <= wr_now && dp_addr_q == ssfe_pkg::OFS_CTRL && hwdata[ssfe_pkg::CTRL_GO];
      end
   end

   assign clr_now = wr_now && dp_addr_q == ssfe_pkg::OFS_CTRL && hwdata[ssfe_pkg::CTRL_CLR];

   // ****************************************************************
   // Encoders
   // ****************************************************************
   assign enc.len_dm = len_q;
   assign enc.wid_dm = wid_q;
   assign enc.size_known = cfg_q[ssfe_pkg::CFG_SIZE_KNOWN];
   assign enc.lat_dm = lat_dm_q;
   assign enc.lat_right = lat_right_q;
   assign enc.lat_known = cfg_q[ssfe_pkg::CFG_LAT_KNOWN];
   assign enc.lon_dm = lon_dm_q;
   assign enc.lon_known = cfg_q[ssfe_pkg::CFG_LON_KNOWN];
   assign enc.lon_applied = cfg_q[ssfe_pkg::CFG_LON_APPLIED];

   ssfe_size_enc u_size (
      .enc(enc.size_mp)
   );

   ssfe_offs_enc u_offs (
      .enc(enc.offs_mp)
   );

   always_comb begin
      if (!pos_vacc_known || pos_vacc_m > ssfe_pkg::VACC_150_M) begin
         vacc_code_d = ssfe_pkg::VACC_UNKNOWN;
      end else if (pos_vacc_m > ssfe_pkg::VACC_45_M) begin
         vacc_code_d = ssfe_pkg::VACC_150;
      end else begin
         vacc_code_d = ssfe_pkg::VACC_45;
      end
   end

   // ****************************************************************
   // Output fields
   // ****************************************************************
   // A software go and a position sample both count as valid input.
   assign fire = ce && (go_q || pos_valid);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_valid_q <= 1'b0;
         size_code_q <= ssfe_pkg::SZ_NODATA;
         lat_code_q <= ssfe_pkg::LAT_NODATA;
         lon_code_q <= ssfe_pkg::LON_NODATA;
      end else if (ce) begin
         out_valid_q <= fire && !clr_now;
         if (clr_now) begin
            size_code_q <= ssfe_pkg::SZ_NODATA;
            lat_code_q <= ssfe_pkg::LAT_NODATA;
            lon_code_q <= ssfe_pkg::LON_NODATA;
         end else if (fire) begin
            // length bits high, width bit low
            size_code_q <= enc.size_code;
            lat_code_q <= enc.lat_code;
            lon_code_q <= enc.lon_code;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vacc_code_q <= ssfe_pkg::VACC_UNKNOWN;
         pos_height_q <= 24'h00_0000;
         vel_height_q <= 24'h00_0000;
      end else if (ce) begin
         if (clr_now) begin
            vacc_code_q <= ssfe_pkg::VACC_UNKNOWN;
            pos_height_q <= 24'h00_0000;
            vel_height_q <= 24'h00_0000;
         end else if (pos_valid) begin
            vacc_code_q <= vacc_code_d;
            pos_height_q <= pos_height;
            vel_height_q <= pos_height;
         end
      end
   end

   assign hreadyout = hreadyout_q;
   assign hrdata = hrdata_q;
   assign hresp = hresp_q;
   assign out_valid = out_valid_q;
   assign size_code = size_code_q;
   assign lat_code = lat_code_q;
   assign lon_code = lon_code_q;
   assign vertical_accuracy_code = vacc_code_q;
   assign posmsg_ellipsoid_height = pos_height_q;
   assign velmsg_ellipsoid_height = vel_height_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_go_write;
      wr_now && dp_addr_q == ssfe_pkg::OFS_CTRL && hwdata[ssfe_pkg::CTRL_GO] && !hwdata[ssfe_pkg::CTRL_CLR];
   endsequence

   sequence s_fire_static;
      fire && !clr_now && !pos_valid;
   endsequence

   a_size_oversize: assert property (
      fire && !clr_now && enc.size_known && (len_q > ssfe_pkg::SZ_LEN_MAX_DM || wid_q > ssfe_pkg::SZ_WID_MAX_DM)
      |=> size_code_q == ssfe_pkg::SZ_CODE_MAX)
      else $error("Oversize aircraft did not give size code 15.");

   a_size_fits: assert property (
      fire && !clr_now && enc.size_known && len_q <= ssfe_pkg::SZ_LEN_MAX_DM && wid_q <= ssfe_pkg::SZ_WID_MAX_DM
      |=> size_code_q != ssfe_pkg::SZ_NODATA && $past(len_q) <= ssfe_pkg::sz_len_bound(size_code_q)
      && $past(wid_q) <= ssfe_pkg::sz_wid_bound(size_code_q)
      && (size_code_q == 4'h1 || $past(len_q) > ssfe_pkg::sz_len_bound(size_code_q - 4'h1)
      || $past(wid_q) > ssfe_pkg::sz_wid_bound(size_code_q - 4'h1)))
      else $error("Size code is not the lowest fitting code.");

   a_lat_saturate: assert property (
      fire && !clr_now && enc.lat_known && lat_dm_q >= ssfe_pkg::LAT_CAP_DM
      |=> lat_code_q == {$past(lat_right_q), 2'h3})
      else $error("Large lateral offset did not saturate at six metres.");

   a_lat_nodata_zero: assert property (
      fire && !clr_now && (!enc.lat_known || lat_dm_q < ssfe_pkg::HALF_STEP_DM)
      |=> lat_code_q == ($past(enc.lat_known) ? ssfe_pkg::LAT_ZERO : ssfe_pkg::LAT_NODATA))
      else $error("Lateral no-data or zero pattern is wrong.");

   a_lon_saturate: assert property (
      fire && !clr_now && enc.lon_known && !enc.lon_applied && lon_dm_q > ssfe_pkg::LON_CAP_DM
      |=> lon_code_q == ssfe_pkg::LON_MAX)
      else $error("Large longitudinal offset did not saturate.");

   a_lon_special: assert property (
      fire && !clr_now && (!enc.lon_known || enc.lon_applied)
      |=> lon_code_q == ($past(enc.lon_known) ? ssfe_pkg::LON_APPLIED : ssfe_pkg::LON_NODATA))
      else $error("Longitudinal no-data or applied code is wrong.");

   a_vacc_legal: assert property (
      vacc_code_q != 2'h3 && (!$past(pos_valid && ce && !clr_now) || vacc_code_q != ssfe_pkg::VACC_45
      || $past(pos_vacc_m) <= ssfe_pkg::VACC_45_M))
      else $error("Vertical accuracy code is reserved or too optimistic.");

   a_height_both: assert property (
      pos_valid && ce && !clr_now |=> pos_height_q == $past(pos_height) && vel_height_q == $past(pos_height))
      else $error("Ellipsoid height did not reach both message fields.");

   a_go_to_valid: assert property (
      s_go_write ##1 (ce && !clr_now) |=> out_valid_q ##1 (!ce || !$past(fire && !clr_now) || out_valid_q))
      else $error("A go write did not produce one output valid pulse.");

   a_valid_pulse: assert property (
      s_fire_static ##1 (ce && !go_q && !pos_valid) |=> !out_valid_q)
      else $error("Output valid stayed high longer than one cycle.");
endmodule
`default_nettype wire

// ===== verif/ssfe_asm_model.sv
/*
 * Model of the message assembly logic that takes the encoded fields.
 * Assumes the fields are sampled on the hclk edge where out_valid is high.
 */
`timescale 1ns/100ps
`default_nettype none
module ssfe_asm_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic out_valid,
   input wire logic [1:0] vertical_accuracy_code,
   input wire logic [23:0] posmsg_ellipsoid_height,
   input wire logic [23:0] velmsg_ellipsoid_height,
   output logic [15:0] frame_cnt,
   output logic [1:0] vacc_q,
   output logic [23:0] pos_h_q,
   output logic [23:0] vel_h_q
);
   // ****************************************************************
   // Frame capture
   // ****************************************************************
   // Fields are latched only on the pulse, so a stretched pulse shows as extra frames.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_cnt <= 16'h0000;
         vacc_q <= 2'h0;
         pos_h_q <= 24'h000000;
         vel_h_q <= 24'h000000;
      end else if (out_valid) begin
         frame_cnt <= frame_cnt + 16'h0001;
         vacc_q <= vertical_accuracy_code;
         pos_h_q <= posmsg_ellipsoid_height;
         vel_h_q <= velmsg_ellipsoid_height;
      end
   end
endmodule
`default_nettype wire

// ===== verif/surveillance_static_field_encoder_tb.sv
/*
 * Self-checking bench for the static field encoder top.
 * Assumes one AHB-Lite master (this bench) and the assembler model beside it.
 */
`timescale 1ns/100ps
`default_nettype none
module surveillance_static_field_encoder_tb;
   // ****************************************************************
   // Signals and tables
   // ****************************************************************
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pos_valid = 1'b0, pos_vacc_known = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0, hresp, vacc, cap_vacc;
   logic [23:0] pos_height = 24'h0, pos_h, vel_h, cap_pos, cap_vel;
   logic [15:0] pos_vacc_m = 16'h0, frames;
   logic hreadyout, out_valid;
   logic ce = 1'b1;
   logic [3:0] size_code;
   logic [2:0] lat_code;
   logic [4:0] lon_code;
   int bad_count = 0, num_checks = 0, cyc = 0;
   localparam logic [31:0] DT [8] = '{32'h01f400f0, 32'h00e60096, 32'h00e60097, 32'h014b015e,
      32'h03200352, 32'h00640353, 32'h03850064, 32'h011d02bc};
   localparam logic [31:0] AT [8] = '{32'h00000000, 32'h001e0409, 32'h0028000a, 32'h023a041d,
      32'h024d001e, 32'h024e0431, 32'h02590032, 32'h03ff07ff};
   localparam logic [11:0] ET [8] = '{12'h982, 12'h183, 12'h223, 12'h5be, 12'he5e, 12'hfdf, 12'hf7f, 12'hcff};
   localparam logic [16:0] VT [5] = '{17'h1002d, 17'h1002e, 17'h10096, 17'h10097, 17'h00000};
   localparam logic [1:0] VE [5] = '{2'h2, 2'h1, 2'h1, 2'h0, 2'h0};
   always #5 hclk = ~hclk;
   ssfe_top ssfe_top_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pos_valid(pos_valid), .pos_height(pos_height),
      .pos_vacc_known(pos_vacc_known), .pos_vacc_m(pos_vacc_m), .out_valid(out_valid), .size_code(size_code),
      .lat_code(lat_code), .lon_code(lon_code), .vertical_accuracy_code(vacc),
      .posmsg_ellipsoid_height(pos_h), .velmsg_ellipsoid_height(vel_h));
   ssfe_asm_model ssfe_asm_model_inst (.hclk(hclk), .hresetn(hresetn), .out_valid(out_valid),
      .vertical_accuracy_code(vacc), .posmsg_ellipsoid_height(pos_h), .velmsg_ellipsoid_height(vel_h),
      .frame_cnt(frames), .vacc_q(cap_vacc), .pos_h_q(cap_pos), .vel_h_q(cap_vel));
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // The master waits on hready itself, so a slower slave still completes.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      haddr <= {24'h000000, a};
      htrans <= ssfe_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      hsel <= 1'b1;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk(32'(hresp), 32'(ssfe_pkg::HRESP_OKAY));
   endtask
   task automatic encode(input logic [31:0] dims, input logic [31:0] ant, input logic [3:0] cfg);
      int n;
      bus(1'b1, ssfe_pkg::OFS_DIMS, dims);
      bus(1'b1, ssfe_pkg::OFS_ANT, ant);
      bus(1'b1, ssfe_pkg::OFS_CFG, {28'h0, cfg});
      bus(1'b1, ssfe_pkg::OFS_CTRL, 32'h1);
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (out_valid !== 1'b1 && n < 4);
      chk(32'(n), 32'h1); // pulse one cycle after go.
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_regs();
      bus(1'b0, ssfe_pkg::OFS_CFG, 32'h0);
      chk(rd, 32'(ssfe_pkg::CFG_RESET)); // cleared after reset.
      bus(1'b0, ssfe_pkg::OFS_STATUS, 32'h0);
      chk(rd, 32'h0); // no data after reset.
      bus(1'b1, 8'h20, 32'hffffffff);
      bus(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, ssfe_pkg::OFS_DIMS, 32'h12345678);
      bus(1'b0, ssfe_pkg::OFS_DIMS, 32'h0);
      chk(rd, 32'h12345678);
   endtask
   task automatic t_fields();
      for (int i = 0; i < 8; i++) begin
         encode(DT[i], AT[i], 4'h7);
         chk(32'({size_code, lat_code, lon_code}), 32'(ET[i])); // coded fields.
         @(posedge hclk);
         chk(32'(out_valid), 32'h0); // single pulse.
         bus(1'b0, ssfe_pkg::OFS_STATUS, 32'h0);
         chk(rd, {20'h0, ET[i][4:0], ET[i][7:5], ET[i][11:8]}); // field order.
      end
      encode(DT[0], AT[7], 4'h0);
      chk(32'({size_code, lat_code, lon_code}), 32'h0); // no data codes.
      encode(DT[0], AT[7], 4'hc);
      chk(32'({size_code, lat_code, lon_code}), 32'h1); // offset applied.
   endtask
   task automatic t_pos();
      logic [15:0] base;
      // Let the frame of the last encode land in the model before taking the base count.
      @(posedge hclk);
      base = frames;
      for (int i = 0; i < 5; i++) begin
         @(posedge hclk);
         pos_valid <= 1'b1;
         pos_height <= 24'hc00000 + 24'(i);
         pos_vacc_known <= VT[i][16];
         pos_vacc_m <= VT[i][15:0];
         @(posedge hclk);
         pos_valid <= 1'b0;
         @(posedge hclk);
         chk(32'(out_valid), 32'h1); // pulse after input.
         chk(32'(vacc), 32'(VE[i])); // accuracy code.
         chk(32'(pos_h), 32'hc00000 + 32'(i)); // position height.
         chk(32'(vel_h), 32'hc00000 + 32'(i)); // velocity height.
         @(posedge hclk);
         chk(32'(out_valid), 32'h0); // single pulse.
         chk(32'(frames), 32'(base) + 32'(i) + 32'h1); // one frame each.
         chk(32'({cap_vacc, cap_vel}), {6'h0, VE[i], 24'hc00000 + 24'(i)}); // captured frame.
         chk(32'(cap_pos), 32'hc00000 + 32'(i)); // captured position height.
      end
   endtask
   task automatic t_clear();
      bus(1'b1, ssfe_pkg::OFS_CTRL, 32'h2);
      chk(32'({size_code, lat_code, lon_code, vacc}), 32'h0); // clear to no data.
      chk(32'(pos_h), 32'h0); // height cleared.
      bus(1'b0, ssfe_pkg::OFS_HEIGHT, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, ssfe_pkg::OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
   endtask
   task automatic t_hold();
      @(posedge hclk);
      ce <= 1'b0;
      pos_valid <= 1'b1;
      pos_height <= 24'h0a0a0a;
      @(posedge hclk);
      pos_valid <= 1'b0;
      ce <= 1'b1;
      repeat (2) @(posedge hclk);
      chk(32'(out_valid), 32'h0); // no pulse while frozen.
      chk(32'(pos_h), 32'h0); // fields frozen while disabled.
   endtask
   // ****************************************************************
   // Sequence and timeout
   // ****************************************************************
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_fields();
      t_pos();
      t_clear();
      t_hold();
      wrap_up();
   end
   // The ceiling is over twenty times the two hundred or so cycles the run needs.
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         wrap_up();
      end
   end
endmodule
`default_nettype wire
